// ### pkg/temp_pwm_defs.vh
// constants of the temperature pulse encoder: frame timing, slot edges,
// register offsets, field positions and reset values.
// assumes inclusion by bare name from the rtl files.
`ifndef TEMP_PWM_DEFS_VH
`define TEMP_PWM_DEFS_VH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define TICK_PERIOD_NS 50000
`define PWM_FRAME_LAST 11'h7ff
// high times in ticks of a 2048-tick frame
`define PWM_LEAD_TICKS 11'h100
`define PWM_DATA_END 11'h500
`define PWM_UFL_TICKS 11'h580
`define PWM_OFL_TICKS 11'h600
`define PWM_FE_TICKS 11'h680

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_THRESH 8'h04
`define REG_HYST 8'h08
`define REG_OBJ 8'h0c
`define REG_AMB 8'h10
`define REG_IRQ_STAT 8'h14
`define REG_IRQ_MASK 8'h18

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define FLD_OVH 3
`define FLD_OVL 2
`define FLD_FE 1
`define CTRL_POL 0
`define CTRL_DRIVE 4
`define CTRL_PIN 5
`define IRQ_FRAME 0
`define IRQ_UFL 1
`define IRQ_OFL 2
`define IRQ_FE 3
`define IRQ_RELAY 4
`define IRQ_W 5
// 95 C and 5 C on the -20..120 C object scale of 12 bits
`define RST_THRESH 12'hd24
`define RST_HYST 12'h092
`define RST_POL 1'b0
`define RST_DRIVE_ON 1'b1
`define RST_MASK 5'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### rtl/pwm_slot_gen.v
// one pulse output channel: holds the frame's high time and draws the pulse.
// assumes a shared tick count and a one-cycle frame start pulse.
`include "temp_pwm_defs.vh"

module pwm_slot_gen (
  input wire ref_clk,
  input wire sys_rst,
  input wire frameStart,
  input wire [10:0] tickCnt,
  input wire [10:0] highTicks,
  output reg pwmOut
);

  reg [10:0] highHeld_r;

  // ---------------------------------------------------------------
  // frame latch and compare
  // ---------------------------------------------------------------
  // high time frozen per frame so one frame never mixes two values
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      highHeld_r <= `PWM_LEAD_TICKS;
      pwmOut <= 1'b0;
    end else begin
      if (frameStart) begin
        highHeld_r <= highTicks; // [R17]
      end
      // every high time is at least the lead buffer, so each frame opens high
      pwmOut <= (tickCnt < highHeld_r); // [R2] [R3]
    end
  end

endmodule // pwm_slot_gen

// ### rtl/relay_hyst_cmp.v
// relay threshold comparator with hysteresis and selectable polarity.
// assumes a 12-bit temperature code from logic on the same clock.
`include "temp_pwm_defs.vh"

module relay_hyst_cmp (
  input wire ref_clk,
  input wire sys_rst,
  input wire [11:0] tempCode,
  input wire [11:0] threshold,
  input wire [11:0] hysteresis,
  input wire nonInverting,
  output reg driveOn
);

  reg above_r;
  reg above_nxt;
  reg [11:0] lowLimit;

  // ---------------------------------------------------------------
  // hysteresis state
  // ---------------------------------------------------------------
  // release level saturates at zero when hysteresis exceeds threshold
  always @* begin
    lowLimit = (threshold > hysteresis) ? (threshold - hysteresis) : 12'h000;
    above_nxt = above_r;
    if (!above_r && (tempCode > threshold)) begin
      above_nxt = 1'b1; // [R11] [R13]
    end else if (above_r && (tempCode <= lowLimit)) begin
      above_nxt = 1'b0; // [R16]
    end
  end

  // drive state follows polarity: inverting turns off above threshold
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      above_r <= 1'b0;
      driveOn <= `RST_DRIVE_ON;
    end else begin
      above_r <= above_nxt;
      driveOn <= nonInverting ? above_nxt : !above_nxt; // [R12]
    end
  end

endmodule // relay_hyst_cmp

// ### rtl/temp_pwm_encoder.v
// temperature pulse-width encoder with relay comparator and register slave.
// assumes temperature codes and range flags come from logic on ref_clk,
// and software reaches the settings over an AXI4-Lite port.
`include "temp_pwm_defs.vh"

// Behaviour
// R1: each frame lasts 2048 ticks of 50 us, 102.4 ms.
// R2: every frame opens with a high lead buffer.
// R3: data slot spans 1/8 to 5/8 of frame; high fraction carries value.
// R4: pulse data value is quantised to 10 bits.
// R5: normal temperature maps linearly onto 12.5 to 62.5 percent duty.
// R6: underflow 68.75, overflow 75, fatal error 81.25 percent duty.
// R7: stored settings are checked; uncorrectable errors flagged on outputs.
// R8: ambient out of range flags both outputs, withholds both values.
// R9: object out of range clamps object duty and data; ambient stays normal.
// R10: ambient low or high forces object data 000 or fff, sets flag.
// R11: relay comparator is digital, 12-bit, inverting by default, stored settings.
// R12: inverting switches relay off above threshold; non-inverting switches on.
// R13: comparator uses object temperature, 95 C threshold, 5 C hysteresis.
// R14: the reader of the open-drain relay pin supplies a pull-up.
// R15: register holds data in 15:4, overflow 3, underflow 2, fatal 1.
// R16: after switching, return only once below threshold by the hysteresis.
// R17: value and condition latched at frame start; frames never mix values.
module temp_pwm_encoder #(
  parameter integer TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [11:0] objTemp,
  input wire objBelowRange,
  input wire objAboveRange,
  input wire [11:0] ambTemp,
  input wire ambBelowRange,
  input wire ambAboveRange,
  input wire eccFatal,
  output wire objPwmOut,
  output wire ambPwmOut,
  input wire relayDriverOutI,
  output reg relayDriverOutO,
  output wire relayDriverOutOe,
  output reg irq
);

  localparam [15:0] TICK_LAST = TICK_CYCLES[15:0] - 16'h0001;

  reg [15:0] tickDiv_r;
  reg [10:0] tickCnt_r;
  reg frameStart_r, ctrlPol_r, setPar_r, awHave_r, wHave_r, pinLevel_r, relayPrev_r;
  reg [11:0] thresh_r, hyst_r, thresh_nxt, hyst_nxt, objData, ambData;
  reg [15:0] objReg_r, ambReg_r;
  reg [`IRQ_W-1:0] irqStat_r, irqMask_r, irqStat_nxt, evt;
  reg [7:0] awAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg [2:0] pinSync_r;
  reg [31:0] rdData;
  reg rdHit, wrHit, ctrlPol_nxt, special;
  reg [10:0] objHigh, ambHigh, specHigh;
  wire fatalErr, ambBad, doWrite, arTake, relayOn;
  wire [7:0] wrAddr, rdAddr;

  // ---------------------------------------------------------------
  // frame timing
  // ---------------------------------------------------------------
  // tick divider and 2048-tick frame counter; 11 bits wrap on their own
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      tickDiv_r <= 16'h0000;
      tickCnt_r <= 11'h000;
      frameStart_r <= 1'b0;
    end else begin
      frameStart_r <= 1'b0;
      if (tickDiv_r == TICK_LAST) begin
        tickDiv_r <= 16'h0000;
        tickCnt_r <= tickCnt_r + 11'h001; // [R1]
        if (tickCnt_r == `PWM_FRAME_LAST) frameStart_r <= 1'b1; // [R1]
      end else begin
        tickDiv_r <= tickDiv_r + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // condition and value encoding
  // ---------------------------------------------------------------
  // parity over the stored settings is kept at write time; a mismatch
  // later means the settings were disturbed and cannot be repaired here
  assign fatalErr = eccFatal | (setPar_r != ^{ctrlPol_r, thresh_r, hyst_r}); // [R7]
  assign ambBad = ambBelowRange | ambAboveRange;

  // fatal error outranks the ambient range codes
  always @* begin
    special = fatalErr | ambBad;
    specHigh = fatalErr ? `PWM_FE_TICKS :
               (ambAboveRange ? `PWM_OFL_TICKS : `PWM_UFL_TICKS); // [R6] [R7] [R8]
    // register data: ambient range overrides everything, then object clamp
    if (ambBelowRange) begin
      objData = 12'h000; // [R10]
    end else if (ambAboveRange) begin
      objData = 12'hfff; // [R10]
    end else if (objBelowRange) begin
      objData = 12'h000; // [R9]
    end else if (objAboveRange) begin
      objData = 12'hfff; // [R9]
    end else begin
      objData = objTemp;
    end
    ambData = ambBelowRange ? 12'h000 : (ambAboveRange ? 12'hfff : ambTemp); // [R8] [R15]
    // top ten bits of the code step the data slot tick by tick
    if (special) begin
      objHigh = specHigh;
    end else if (objBelowRange) begin
      objHigh = `PWM_LEAD_TICKS; // [R9]
    end else if (objAboveRange) begin
      objHigh = `PWM_DATA_END; // [R9]
    end else begin
      objHigh = `PWM_LEAD_TICKS + {1'b0, objTemp[11:2]}; // [R3] [R4] [R5]
    end
    ambHigh = special ? specHigh : `PWM_LEAD_TICKS + {1'b0, ambTemp[11:2]}; // [R4] [R5] [R9]
  end

  // channel 0 object, channel 1 ambient
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gCh
      wire chOut;
      pwm_slot_gen uSlot (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .frameStart(frameStart_r),
        .tickCnt(tickCnt_r),
        .highTicks(ch ? ambHigh : objHigh),
        .pwmOut(chOut)
      );
    end
  endgenerate

  assign objPwmOut = gCh[0].chOut;
  assign ambPwmOut = gCh[1].chOut;

  // readable temperature words, refreshed with each frame
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      objReg_r <= 16'h0000;
      ambReg_r <= 16'h0000;
    end else if (frameStart_r) begin
      objReg_r <= {objData, ambAboveRange, ambBelowRange, fatalErr, 1'b0}; // [R15] [R17]
      ambReg_r <= {ambData, ambAboveRange, ambBelowRange, fatalErr, 1'b0}; // [R15] [R17]
    end
  end

  // ---------------------------------------------------------------
  // relay comparator and open-drain pin
  // ---------------------------------------------------------------
  // compares the clamped object value that software also reads
  relay_hyst_cmp uRelay (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tempCode(objReg_r[15:4]),
    .threshold(thresh_r),
    .hysteresis(hyst_r),
    .nonInverting(ctrlPol_r),
    .driveOn(relayOn)
  );

  // the pin is only ever pulled low; a pull-up outside gives the high level
  assign relayDriverOutOe = relayOn; // [R11] [R14]

  // pin sense: a change counts once the second and third stages agree
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      relayDriverOutO <= 1'b0;
      pinSync_r <= 3'h0;
      pinLevel_r <= 1'b0;
      relayPrev_r <= `RST_DRIVE_ON;
    end else begin
      relayDriverOutO <= 1'b0;
      pinSync_r <= {pinSync_r[1:0], relayDriverOutI};
      if (pinSync_r[1] == pinSync_r[2]) pinLevel_r <= pinSync_r[2];
      relayPrev_r <= relayOn;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  assign arTake = s_axi_arvalid & s_axi_arready;
  assign rdAddr = {s_axi_araddr[7:2], 2'b00};

  // a read of the status clears it, but an event in that cycle survives
  always @* begin
    evt[`IRQ_FRAME] = frameStart_r;
    evt[`IRQ_UFL] = frameStart_r & ambBelowRange;
    evt[`IRQ_OFL] = frameStart_r & ambAboveRange;
    evt[`IRQ_FE] = frameStart_r & fatalErr;
    evt[`IRQ_RELAY] = relayOn ^ relayPrev_r;
    irqStat_nxt = ((arTake && (rdAddr == `REG_IRQ_STAT)) ? {`IRQ_W{1'b0}} : irqStat_r) | evt;
  end

  // ---------------------------------------------------------------
  // register write path
  // ---------------------------------------------------------------
  assign wrAddr = {awAddr_r[7:2], 2'b00};
  assign doWrite = awHave_r & wHave_r & ~s_axi_bvalid;

  // byte lanes 0 and 1 cover every writable field
  always @* begin
    ctrlPol_nxt = ctrlPol_r;
    thresh_nxt = thresh_r;
    hyst_nxt = hyst_r;
    wrHit = 1'b1;
    case (wrAddr)
      `REG_CTRL: if (wStrb_r[0]) ctrlPol_nxt = wData_r[`CTRL_POL];
      `REG_THRESH: thresh_nxt = {wStrb_r[1] ? wData_r[11:8] : thresh_r[11:8],
                                 wStrb_r[0] ? wData_r[7:0] : thresh_r[7:0]};
      `REG_HYST: hyst_nxt = {wStrb_r[1] ? wData_r[11:8] : hyst_r[11:8],
                             wStrb_r[0] ? wData_r[7:0] : hyst_r[7:0]};
      `REG_OBJ, `REG_AMB, `REG_IRQ_STAT, `REG_IRQ_MASK: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // address and data are taken in either order; response after both
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      ctrlPol_r <= `RST_POL;
      thresh_r <= `RST_THRESH;
      hyst_r <= `RST_HYST;
      setPar_r <= ^{`RST_POL, `RST_THRESH, `RST_HYST};
      irqMask_r <= `RST_MASK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHave_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHave_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
        ctrlPol_r <= ctrlPol_nxt; // [R11]
        thresh_r <= thresh_nxt; // [R11]
        hyst_r <= hyst_nxt; // [R11]
        setPar_r <= ^{ctrlPol_nxt, thresh_nxt, hyst_nxt}; // [R7]
        if ((wrAddr == `REG_IRQ_MASK) && wStrb_r[0]) irqMask_r <= wData_r[`IRQ_W-1:0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // register read path
  // ---------------------------------------------------------------
  always @* begin
    rdData = 32'h00000000;
    rdHit = 1'b1;
    case (rdAddr)
      `REG_CTRL: begin
        rdData[`CTRL_POL] = ctrlPol_r;
        rdData[`CTRL_DRIVE] = relayOn;
        rdData[`CTRL_PIN] = pinLevel_r;
      end
      `REG_THRESH: rdData[11:0] = thresh_r;
      `REG_HYST: rdData[11:0] = hyst_r;
      `REG_OBJ: rdData[15:0] = objReg_r; // [R15]
      `REG_AMB: rdData[15:0] = ambReg_r; // [R15]
      `REG_IRQ_STAT: rdData[`IRQ_W-1:0] = irqStat_r;
      `REG_IRQ_MASK: rdData[`IRQ_W-1:0] = irqMask_r;
      default: rdHit = 1'b0;
    endcase
  end

  // one read at a time; data answer one cycle after the address is taken
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
      irqStat_r <= {`IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      if (arTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdData;
        s_axi_rresp <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      irqStat_r <= irqStat_nxt;
      irq <= |(irqStat_nxt & irqMask_r);
    end
  end

endmodule // temp_pwm_encoder

// ### verif/pwm_capture_model.sv
// capture model of the pulse reader on the far side, with the relay pull-up.
// assumes the pulse outputs run on the same clock; counts are in cycles.
module pwm_capture_model (
  input wire logic ref_clk,
  input wire logic objPwm,
  input wire logic ambPwm,
  input wire logic relayO,
  input wire logic relayOe,
  output logic relayPin,
  output int objHigh,
  output int ambHigh,
  output int period,
  output int rises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic objPrev = 1'b0;
  logic ambPrev = 1'b0;
  int objCnt;
  int ambCnt;
  int prdCnt;
  // a released drain floats up to the reader's pull-up
  assign relayPin = relayOe ? relayO : 1'b1;
  // high length latched at each fall, period at each rise
  always @(posedge ref_clk) begin
    objPrev <= objPwm;
    ambPrev <= ambPwm;
    objCnt <= objPwm ? objCnt + 1 : 0;
    ambCnt <= ambPwm ? ambCnt + 1 : 0;
    prdCnt <= (objPwm && !objPrev) ? 1 : prdCnt + 1;
    if (!objPwm && objPrev) objHigh <= objCnt;
    if (!ambPwm && ambPrev) ambHigh <= ambCnt;
    if (objPwm && !objPrev) begin
      period <= prdCnt;
      rises <= rises + 1;
    end
  end
endmodule // pwm_capture_model

// ### verif/temp_pwm_encoder_asserts.sv
// checker for the temperature pulse encoder: frame, pulse and bus timing.
// assumes it is bound into temp_pwm_encoder with the same TICK_CYCLES.
module temp_pwm_encoder_asserts #(
  parameter integer TICK_CYCLES = 1000
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire objPwmOut,
  input wire ambPwmOut,
  input wire relayDriverOutO,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  localparam int FRM = 2048 * TICK_CYCLES;
  localparam int LEAD = 256 * TICK_CYCLES;
  localparam int TOP = 1664 * TICK_CYCLES;
  logic objPrev;
  logic [1:0] riseCnt;
  int hiCnt;
  int prd;
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  // the first period is skipped: the reset frame is not tick aligned
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      objPrev <= 1'b0;
      riseCnt <= 2'd0;
      hiCnt <= 0;
      prd <= 0;
    end else begin
      objPrev <= objPwmOut;
      hiCnt <= objPwmOut ? hiCnt + 1 : 0;
      prd <= (objPwmOut && !objPrev) ? 1 : prd + 1;
      if (objPwmOut && !objPrev && riseCnt != 2'd2) begin
        riseCnt <= riseCnt + 2'd1;
      end
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  chk_frame_period: assert property (riseCnt == 2'd2 && objPwmOut && !objPrev |-> prd == FRM)
    else $error("object frame period wrong");
  chk_lead_min: assert property (!objPwmOut && objPrev |-> hiCnt >= LEAD)
    else $error("pulse shorter than lead buffer");
  chk_high_max: assert property (objPwmOut |-> hiCnt < TOP)
    else $error("pulse longer than fatal slot");
  chk_tick_grain: assert property (!objPwmOut && objPrev |-> hiCnt % TICK_CYCLES == 0)
    else $error("pulse not whole ticks");
  chk_chan_start: assert property ($rose(objPwmOut) == $rose(ambPwmOut))
    else $error("channels start frames apart");
  chk_drain_only: assert property (relayDriverOutO == 1'b0)
    else $error("relay pin driven high");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_wr_busy: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open during response");
endmodule // temp_pwm_encoder_asserts

bind temp_pwm_encoder temp_pwm_encoder_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .objPwmOut(objPwmOut), .ambPwmOut(ambPwmOut),
  .relayDriverOutO(relayDriverOutO), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);

// ### verif/temp_pwm_encoder_tb.sv
// testbench of the temperature pulse encoder: bus tasks and frame checks.
// assumes a short tick (TC cycles) so that a frame takes 4096 cycles.
`include "temp_pwm_defs.vh"
module temp_pwm_encoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 2;
  localparam int LIM = 3 * 2048 * TC;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [31:0] wData = 32'h0;
  logic [11:0] objTemp = 12'h000, ambTemp = 12'h000;
  logic [4:0] cond = 5'h00; // fatal, amb over, amb under, obj above, obj below
  wire awReady, wReady, bValid, arReady, rValid, objPwm, ambPwm, relayPin, relayO, relayOe, irq;
  wire [1:0] bResp, rResp;
  wire [31:0] rData;
  int objHigh, ambHigh, period, rises;
  int errTotal = 0, numChecks = 0;
  logic [31:0] rd;
  logic [1:0] rs;

  temp_pwm_encoder #(.TICK_CYCLES(TC)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .objTemp(objTemp), .objBelowRange(cond[0]), .objAboveRange(cond[1]),
    .ambTemp(ambTemp), .ambBelowRange(cond[2]), .ambAboveRange(cond[3]), .eccFatal(cond[4]),
    .objPwmOut(objPwm), .ambPwmOut(ambPwm), .relayDriverOutI(relayPin),
    .relayDriverOutO(relayO), .relayDriverOutOe(relayOe), .irq(irq)
  );
  pwm_capture_model cap (
    .ref_clk(ref_clk), .objPwm(objPwm), .ambPwm(ambPwm), .relayO(relayO),
    .relayOe(relayOe), .relayPin(relayPin), .objHigh(objHigh), .ambHigh(ambHigh),
    .period(period), .rises(rises)
  );

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // report and bus tasks
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch at %0t ns: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic fail(input string m);
    errTotal++;
    $display("mismatch at %0t ns: %s", $time, m);
    results();
  endtask
  // ready is raised late on purpose so the slave must hold its answer
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid && !bReady) bReady <= 1'b1;
    end while (!(bValid && bReady) && n < 64);
    rs = bResp;
    bReady <= 1'b0;
    if (n >= 64) fail("write timeout");
  endtask
  task automatic axiRd(input logic [7:0] a);
    int n;
    @(posedge ref_clk);
    arAddr <= a;
    arValid <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid && !rReady) rReady <= 1'b1;
    end while (!(rValid && rReady) && n < 64);
    rd = rData;
    rs = rResp;
    rReady <= 1'b0;
    if (n >= 64) fail("read timeout");
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, e, input string s);
    axiRd(a);
    chk(rd & m, e, s);
  endtask
  // sets the inputs, waits out a frame launched after them, then compares widths
  task automatic runFrame(input logic [11:0] o, a, input logic [4:0] c, input int eo, ea);
    int n;
    @(posedge ref_clk);
    objTemp <= o;
    ambTemp <= a;
    cond <= c;
    n = 0;
    while (objPwm !== 1'b0 && n < LIM) begin @(posedge ref_clk); n++; end
    while (objPwm !== 1'b1 && n < LIM) begin @(posedge ref_clk); n++; end
    while ((objPwm | ambPwm) !== 1'b0 && n < LIM) begin @(posedge ref_clk); n++; end
    if (n >= LIM) fail("frame timeout");
    @(posedge ref_clk);
    chk(objHigh, eo * TC, "object width");
    chk(ambHigh, ea * TC, "ambient width");
    if (rises > 2) chk(period, 2048 * TC, "frame period");
  endtask
  function automatic int nrm(input logic [11:0] c);
    return 256 + c / 4; // lead of 1/8 frame plus 10-bit data
  endfunction
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdChk(`REG_THRESH, 32'hfff, 32'hd24, "threshold reset");
    rdChk(`REG_HYST, 32'hfff, 32'h092, "hysteresis reset");
    rdChk(`REG_CTRL, 32'h1, 32'h0, "polarity reset");
    rdChk(8'hfc, 32'hffffffff, 32'h0, "unmapped read data");
    chk(rs, 2'h2, "unmapped read resp");
    axiWr(8'hfc, 32'h1);
    chk(rs, 2'h2, "unmapped write resp");
    chk(relayOe, 1'b1, "relay on after reset");
    $display("test reset done");
    runFrame(12'hfff, 12'h000, 5'h00, nrm(12'hfff), 256);
    rdChk(`REG_OBJ, 32'hffff, 32'hfff0, "object word");
    chk(relayOe, 1'b0, "relay off above threshold");
    chk(relayPin, 1'b1, "pin pulled up");
    rdChk(`REG_CTRL, 32'h30, 32'h20, "drive and pin bits");
    runFrame(12'h123, 12'h800, 5'h00, nrm(12'h123), nrm(12'h800));
    $display("test normal done");
    runFrame(12'h123, 12'h400, 5'h01, 256, 512);
    rdChk(`REG_OBJ, 32'hffff, 32'h0000, "object clamp low");
    runFrame(12'h123, 12'h400, 5'h02, 1280, 512);
    rdChk(`REG_OBJ, 32'hffff, 32'hfff0, "object clamp high");
    runFrame(12'h123, 12'h400, 5'h04, 1408, 1408);
    rdChk(`REG_OBJ, 32'hffff, 32'h0004, "ambient under word");
    runFrame(12'h123, 12'h400, 5'h08, 1536, 1536);
    rdChk(`REG_OBJ, 32'hffff, 32'hfff8, "ambient over word");
    runFrame(12'h123, 12'h400, 5'h1c, 1664, 1664);
    rdChk(`REG_OBJ, 32'h2, 32'h2, "fatal flag");
    $display("test conditions done");
    runFrame(12'hd25, 12'h400, 5'h00, nrm(12'hd25), 512);
    chk(relayOe, 1'b0, "relay off just above");
    runFrame(12'hc93, 12'h400, 5'h00, nrm(12'hc93), 512);
    chk(relayOe, 1'b0, "inside hysteresis");
    runFrame(12'hc92, 12'h400, 5'h00, nrm(12'hc92), 512);
    chk(relayOe, 1'b1, "back below hysteresis");
    axiWr(`REG_CTRL, 32'h1);
    repeat (4) @(posedge ref_clk);
    chk(relayOe, 1'b0, "non-inverting below");
    runFrame(12'hfff, 12'h400, 5'h00, nrm(12'hfff), 512);
    chk(relayOe, 1'b1, "non-inverting above");
    axiWr(`REG_CTRL, 32'h0);
    $display("test relay done");
    axiRd(`REG_IRQ_STAT);
    axiWr(`REG_IRQ_MASK, 32'h1);
    runFrame(12'hfff, 12'h400, 5'h00, nrm(12'hfff), 512);
    chk(irq, 1'b1, "frame interrupt");
    axiWr(`REG_IRQ_MASK, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0, "interrupt masked");
    axiWr(`REG_IRQ_MASK, 32'h1);
    rdChk(`REG_IRQ_STAT, 32'h1, 32'h1, "frame status");
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0, "status cleared by read");
    $display("test interrupt done");
    results();
  end
endmodule // temp_pwm_encoder_tb
